// ===== rtl/plcp_port.sv
// Launch control port: launch strobe, presence sense and three status pins.
// Assumes synchronous reset, one 100 MHz clock, and a programming engine
// that answers run_start_out with a one-cycle run_done_in and its result.
`timescale 1ns/10ps
`include "plcp_regs.svh"
module plcp_port (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic io_reference_supply_in,
   input wire logic sense_n_in,
   input wire logic launch_n_in,
   input wire logic enable_wr_in,
   input wire logic enable_val_in,
   input wire logic run_done_in,
   input wire logic run_pass_in,
   output logic run_start_out,
   output logic port_active_out,
   output logic trigger_enabled_out,
   output logic pass_n_out,
   output logic pass_oe_out,
   output logic fail_n_out,
   output logic fail_oe_out,
   output logic idle_n_out,
   output logic idle_oe_out
);
   // ==========================================================
   // Input synchronisation
   logic [1:0] pins_sync;
   logic sense_n_s;
   logic launch_n_s;

   // Launch and presence levels enter the clock domain here.
   plcp_sync #(.WIDTH(2)) u_sync (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .async_in({sense_n_in, launch_n_in}),
      .reset_val_in(`PLCP_SYNC_RST),
      .sync_out(pins_sync)
   );
   assign sense_n_s = pins_sync[`PLCP_SENSE_BIT];
   assign launch_n_s = pins_sync[`PLCP_LAUNCH_BIT];

   // ==========================================================
   // Edge capture and stored enable
   logic launch_prev_reg;
   logic launch_prev_next;
   logic enable_reg;
   logic enable_next;
   logic pending_reg;
   logic pending_next;
   logic fall_edge;
   logic active;
   plcp_pkg::plcp_state_e state_reg;
   plcp_pkg::plcp_state_e state_next;

   assign active = io_reference_supply_in && (sense_n_s == `PLCP_PIN_LOW);
   assign fall_edge = launch_prev_reg && !launch_n_s;

   // Enable persists until rewritten; a falling edge at idle is latched.
   always_comb begin
      launch_prev_next = launch_n_s;
      enable_next = enable_reg;
      if (enable_wr_in) begin
         enable_next = enable_val_in;
      end
      pending_next = pending_reg;
      if (state_reg != plcp_pkg::PLCP_IDLE) begin
         pending_next = 1'b0;
      end else if (fall_edge && active && (enable_reg == `PLCP_ENABLE_ON)) begin
         pending_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         launch_prev_reg <= `PLCP_PIN_HIGH;
         enable_reg <= `PLCP_ENABLE_RST;
         pending_reg <= 1'b0;
      end else begin
         launch_prev_reg <= launch_prev_next;
         enable_reg <= enable_next;
         pending_reg <= pending_next;
      end
   end

   // ==========================================================
   // Run sequencing and status pins
   logic pass_reg;
   logic pass_next;
   logic fail_reg;
   logic fail_next;
   logic idle_reg;
   logic idle_next;
   logic start_reg;
   logic start_next;

   // Pass/fail settle one cycle before idle changes in each direction.
   always_comb begin
      state_next = state_reg;
      pass_next = pass_reg;
      fail_next = fail_reg;
      idle_next = idle_reg;
      start_next = 1'b0;
      case (state_reg)
         plcp_pkg::PLCP_IDLE: begin
            idle_next = `PLCP_PIN_LOW;
            if (pending_reg) begin
               pass_next = `PLCP_PIN_HIGH;
               fail_next = `PLCP_PIN_HIGH;
               state_next = plcp_pkg::PLCP_CLEAR;
            end
         end
         plcp_pkg::PLCP_CLEAR: begin
            idle_next = `PLCP_PIN_HIGH;
            start_next = 1'b1;
            state_next = plcp_pkg::PLCP_BUSY;
         end
         plcp_pkg::PLCP_BUSY: begin
            if (run_done_in) begin
               pass_next = run_pass_in ? `PLCP_PIN_LOW : `PLCP_PIN_HIGH;
               fail_next = run_pass_in ? `PLCP_PIN_HIGH : `PLCP_PIN_LOW;
               state_next = plcp_pkg::PLCP_REPORT;
            end
         end
         plcp_pkg::PLCP_REPORT: begin
            idle_next = `PLCP_PIN_LOW;
            state_next = plcp_pkg::PLCP_IDLE;
         end
         default: begin
            state_next = plcp_pkg::PLCP_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         state_reg <= plcp_pkg::PLCP_IDLE;
         pass_reg <= `PLCP_PIN_HIGH;
         fail_reg <= `PLCP_PIN_HIGH;
         idle_reg <= `PLCP_PIN_LOW;
         start_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pass_reg <= pass_next;
         fail_reg <= fail_next;
         idle_reg <= idle_next;
         start_reg <= start_next;
      end
   end

   // Status pins drive only while the reference supply is present.
   assign pass_n_out = pass_reg;
   assign fail_n_out = fail_reg;
   assign idle_n_out = idle_reg;
   assign pass_oe_out = io_reference_supply_in;
   assign fail_oe_out = io_reference_supply_in;
   assign idle_oe_out = io_reference_supply_in;
   assign run_start_out = start_reg;
   assign port_active_out = active;
   assign trigger_enabled_out = enable_reg;

   // ==========================================================
   // Checks
   sequence seq_launch_taken;
      state_reg == plcp_pkg::PLCP_IDLE && pending_reg;
   endsequence

   sequence seq_busy_shown;
      pass_n_out && fail_n_out && !idle_n_out ##1 pass_n_out && fail_n_out && idle_n_out;
   endsequence

   AST_LAUNCH_ORDER: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      seq_launch_taken |=> seq_busy_shown) else $error("busy order wrong");
   AST_DONE_ORDER: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (state_reg == plcp_pkg::PLCP_BUSY && run_done_in) |=> idle_n_out ##1 !idle_n_out)
      else $error("done order wrong");
   AST_GATED_LAUNCH: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(pending_reg) |-> $past(active) && $past(enable_reg)) else $error("launch not gated");
   AST_IDLE_LOW: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (state_reg == plcp_pkg::PLCP_IDLE) |-> !idle_n_out) else $error("idle not low");
   AST_EXCLUSIVE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !(!pass_n_out && !fail_n_out)) else $error("pass and fail both low");
   AST_BUSY_HIGH: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (state_reg == plcp_pkg::PLCP_BUSY) |-> pass_n_out && fail_n_out) else $error("status low while busy");
   AST_ENABLE_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !enable_wr_in |=> $stable(enable_reg)) else $error("enable changed");
   AST_ENABLE_WRITE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      enable_wr_in |=> enable_reg == $past(enable_val_in)) else $error("enable write lost");
   AST_NO_RELAUNCH: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (state_reg == plcp_pkg::PLCP_BUSY) |=> !pending_reg) else $error("edge kept while busy");
   AST_OE_SUPPLY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      idle_oe_out == io_reference_supply_in) else $error("drive without supply");

   // ==========================================================
   // Further checks on pulses, results and reset
   // While a result is reported, exactly one status pin shows it and busy still stands.
   sequence seq_result_shown;
      !(pass_n_out && fail_n_out) && idle_n_out;
   endsequence

   // The engine start is a single pulse issued while busy is already shown.
   AST_START_PULSE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      run_start_out |-> idle_n_out ##1 !run_start_out) else $error("start not a single pulse");

   // The result is on the pins for a cycle before idle returns low.
   AST_RESULT_FIRST: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (state_reg == plcp_pkg::PLCP_REPORT) |-> seq_result_shown) else $error("result not shown before idle");

   // Pass goes low only in answer to a finished, successful run.
   AST_PASS_SOURCE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $fell(pass_n_out) |-> $past(run_done_in) && $past(run_pass_in)) else $error("pass without success");

   // Fail goes low only in answer to a finished, failed run.
   AST_FAIL_SOURCE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $fell(fail_n_out) |-> $past(run_done_in) && !$past(run_pass_in)) else $error("fail without failure");

   // A qualified falling edge at idle is never dropped.
   AST_EDGE_KEPT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (state_reg == plcp_pkg::PLCP_IDLE && fall_edge && active && enable_reg) |=> pending_reg)
      else $error("launch edge lost");

   // The port counts as active only with supply present and presence held low.
   AST_ACTIVE_FOLLOWS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      port_active_out == (io_reference_supply_in && !sense_n_s)) else $error("active state wrong");

   // Reset leaves the port idle with both result pins high and nothing pending.
   AST_RESET_STATE: assert property (@(posedge sys_clk_in)
      !rst_n_in |=> pass_n_out && fail_n_out && !idle_n_out && !pending_reg && !run_start_out)
      else $error("reset state wrong");
endmodule : plcp_port

// ===== rtl/plcp_regs.svh
// Constants for the launch control port block.
// Assumes inclusion by bare name from rtl/ and one 100 MHz clock.
//
// How it works
// - Status outputs are driven only while the I/O reference supply is present.
// - A run starts only when trigger enable is on and the port is active.
// - Port is active while reference supply is present and presence input is low.
// - Trigger enable is held in a register until explicitly rewritten.
// - Writing one enables port launches, writing zero disables them.
// - Port state outputs show port active and trigger enabled.
// - With no run in progress the idle output is held low.
// - On accepted launch, pass and fail go high first, then idle goes high.
// - At run end, pass and fail show the result first, then idle returns low.
// - Pass output is low only after the latest run succeeded.
// - Fail output is low only after the latest run failed.
// - Launch falling edge at idle is captured in hardware and never lost; edges during a run are dropped.
`ifndef PLCP_REGS_SVH
`define PLCP_REGS_SVH
`define PLCP_CLK_MHZ 100
`define PLCP_POLL_WAIT_MS 100
`define PLCP_POLL_WAIT_CYC (`PLCP_POLL_WAIT_MS * 1000 * `PLCP_CLK_MHZ)
`define PLCP_SYNC_RST 2'h3
`define PLCP_SENSE_BIT 1
`define PLCP_LAUNCH_BIT 0
`define PLCP_ENABLE_RST 1'h0
`define PLCP_ENABLE_ON 1'h1
`define PLCP_PIN_HIGH 1'h1
`define PLCP_PIN_LOW 1'h0
`endif

// ===== rtl/plcp_pkg.sv
// Types shared by the launch control port block.
// Assumes nothing of its surroundings.
package plcp_pkg;
   typedef enum logic [1:0] {
      PLCP_IDLE = 2'b00,
      PLCP_CLEAR = 2'b01,
      PLCP_BUSY = 2'b10,
      PLCP_REPORT = 2'b11
   } plcp_state_e;
endpackage : plcp_pkg

// ===== rtl/plcp_sync.sv
// Two-flop synchroniser for a group of input levels.
// Assumes inputs may change at any time relative to sys_clk_in.
`timescale 1ns/10ps
`include "plcp_regs.svh"
module plcp_sync #(
   parameter int WIDTH = 2
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] async_in,
   input wire logic [WIDTH-1:0] reset_val_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   // Refuse a width that leaves nothing to synchronise.
   if (WIDTH < 1) begin : g_width_check
      $error("plcp_sync needs WIDTH of at least one");
   end

   // First flop feeds only the second one.
   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   // Reset loads the idle pin level of each input.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         meta_reg <= reset_val_in;
         sync_reg <= reset_val_in;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule : plcp_sync

// ===== verification/plcp_engine_model.sv
// Behavioural programming engine that answers the port's run start pulse.
// Assumes it shares the port's clock and sees run_start_out directly.
`timescale 1ns/10ps
// ==========
// Engine model
module plcp_engine_model (
   input wire logic sys_clk_in,
   input wire logic start_in,
   input wire logic result_in,
   input int delay_in,
   output logic done_out,
   output logic pass_out
);
   int count_reg;
   // Counts down after a start, then pulses done with the result for one cycle.
   initial begin
      count_reg = 0;
      done_out = 1'b0;
      pass_out = 1'b0;
   end
   always @(posedge sys_clk_in) begin
      done_out <= 1'b0;
      pass_out <= ~pass_out; // Result line is meaningless outside the done cycle.
      if (start_in) begin
         count_reg <= delay_in;
      end else if (count_reg > 0) begin
         count_reg <= count_reg - 1;
         if (count_reg == 1) begin
            done_out <= 1'b1;
            pass_out <= result_in;
         end
      end
   end
endmodule : plcp_engine_model

// ===== verification/programming_launch_control_port_bench.sv
// Self-checking bench for the launch control port.
// Assumes the port and the engine model share one 100 MHz clock.
`timescale 1ns/10ps
// ==========
// Bench top
module programming_launch_control_port_bench;
   logic clk = 1'b0, rst_n = 1'b0, supply = 1'b1, sense_n = 1'b0, launch_n = 1'b1;
   logic en_wr = 1'b0, en_val = 1'b0, done, rpass, start, active, trig;
   logic pass_n, pass_oe, fail_n, fail_oe, idle_n, idle_oe, result;
   int delay = 6, seed = 44764, miscompares = 0, check_count = 0;
   // Clock of 10 ns period.
   always #5 clk = ~clk;
   plcp_port i_plcp_port (.sys_clk_in(clk), .rst_n_in(rst_n), .io_reference_supply_in(supply),
      .sense_n_in(sense_n), .launch_n_in(launch_n), .enable_wr_in(en_wr), .enable_val_in(en_val),
      .run_done_in(done), .run_pass_in(rpass), .run_start_out(start), .port_active_out(active),
      .trigger_enabled_out(trig), .pass_n_out(pass_n), .pass_oe_out(pass_oe), .fail_n_out(fail_n),
      .fail_oe_out(fail_oe), .idle_n_out(idle_n), .idle_oe_out(idle_oe));
   plcp_engine_model i_plcp_engine_model (.sys_clk_in(clk), .start_in(start), .result_in(result),
      .delay_in(delay), .done_out(done), .pass_out(rpass));
   // Compares one design output with its expected value.
   task automatic check(input logic got, input logic exp, input string what);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s got %b want %b", $time, what, got, exp);
      end
   endtask : check
   // Compares the three status pins with the model's expectation.
   task automatic status(input int p, input int f, input int i, input string what);
      check(pass_n, p[0], what);
      check(fail_n, f[0], what);
      check(idle_n, i[0], what);
   endtask : status
   // Pulses the launch strobe low for four cycles.
   task automatic launch();
      @(posedge clk);
      launch_n <= 1'b0;
      repeat (4) @(posedge clk);
      launch_n <= 1'b1;
   endtask : launch
   // Writes the trigger enable and checks that it is reported.
   task automatic write_enable(input logic v);
      @(posedge clk);
      en_wr <= 1'b1;
      en_val <= v;
      @(posedge clk);
      en_wr <= 1'b0;
      @(posedge clk);
      #1 check(trig, v, "enable");
   endtask : write_enable
   // Launch that must be refused: idle is checked low once, ten cycles after the strobe ends.
   task automatic refused(input string what);
      launch();
      repeat (10) @(posedge clk);
      #1 check(idle_n, 1'b0, what);
   endtask : refused
   // One full run, with a launch edge thrown in while busy.
   task automatic run();
      int n;
      int rnd;
      rnd = $random(seed);
      @(posedge clk);
      result <= rnd[0];
      delay <= 8 + ($random(seed) & 15);
      launch();
      #1 n = 0;
      // Watch for busy first, so idle low is only trusted after the launch was seen.
      while (idle_n !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      status(1, 1, 1, "busy");
      launch();
      #1 n = 0;
      while (idle_n !== 1'b0 && n < 60) begin
         @(posedge clk);
         #1 n++;
      end
      status(!result, result, 0, "done");
      repeat (8) @(posedge clk);
      #1 check(idle_n, 1'b0, "busy edge dropped");
   endtask : run
   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   // Watchdog against a hang.
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      $display("ERROR %0t timeout", $time);
      complete_run();
   end
   // Main sequence.
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 status(1, 1, 0, "reset");
      check(trig, 1'b0, "reset enable");
      check(pass_oe & fail_oe & idle_oe, 1'b1, "oe");
      check(active, 1'b1, "active");
      refused("disabled");
      write_enable(1'b1);
      $display("test reset done");
      for (int i = 0; i < 6; i++) run();
      $display("test runs done");
      write_enable(1'b0);
      refused("disabled again");
      write_enable(1'b1);
      @(posedge clk);
      supply <= 1'b0;
      sense_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check(pass_oe | fail_oe | idle_oe, 1'b0, "no supply oe");
      check(active, 1'b0, "inactive");
      launch();
      supply <= 1'b1;
      repeat (10) @(posedge clk);
      #1 check(idle_n, 1'b0, "absent");
      check(active, 1'b0, "no sense");
      refused("sense high");
      @(posedge clk);
      sense_n <= 1'b0;
      supply <= 1'b0;
      repeat (3) @(posedge clk);
      refused("supply gone");
      check(active, 1'b0, "no supply");
      @(posedge clk);
      supply <= 1'b1;
      @(posedge clk);
      #1 check(active, 1'b1, "back");
      check(trig, 1'b1, "kept");
      $display("test refusals done");
      complete_run();
   end
endmodule : programming_launch_control_port_bench
